// ==== hdl/ewsh_consts.vh ====
// constants for the transmit edge wave shaper: register indices, fields, codes, reset values
// Behaviour
// - firmware codes 2-3: falling style field [6:4] is the falling-edge time constant; code 1 ignores it
// - table codes 4-6: falling style field picks lookup table 0 to 3
// - firmware codes 2-3: rising style field [2:0] is the rising-edge time constant; code 1 ignores it
// - table codes 4-6: rising style field picks lookup table 0 to 3
// - one scaling bit doubles every transition state, both edges together
// - scaling bit clear: each transition state lasts one carrier cycle
// - scaling bit set: each transition state lasts two carrier cycles
// - five-bit count of transition states, shared by rising and falling edge
// - eight-bit residual carrier level during pause, 0x00 none, 0xFF full
// - falling-edge style code sits in the upper nibble of the kind register
// - rising-edge style code sits in the lower nibble, same code set
// - codes 1, 2, 3 give one, two, three linear segments
// - code 4: lookup table shape, no supply adaptation
// - code 5: lookup table shape, supply adaptation plus correction
// - code 6: lookup table shape, supply adaptation without correction
`ifndef EWSH_CONSTS_VH
`define EWSH_CONSTS_VH

// register indices; byte address is four times the index
`define EWSH_IDX_STYLE   8'h1E
`define EWSH_IDX_LENGTH  8'h1F
`define EWSH_IDX_RESID   8'h20
`define EWSH_IDX_KIND    8'h21
`define EWSH_IDX_STATUS  8'h3F

// reset values
`define EWSH_RST_STYLE   8'h00
`define EWSH_RST_LENGTH  8'h00
`define EWSH_RST_RESID   8'h00
`define EWSH_RST_KIND    8'h00

// field positions
`define EWSH_FALL_CFG    6:4
`define EWSH_RISE_CFG    2:0
`define EWSH_SCALE_BIT   7
`define EWSH_NSTATE      4:0
`define EWSH_KIND_FALL   7:4
`define EWSH_KIND_RISE   3:0

// write masks that keep reserved bits at zero
`define EWSH_MASK_STYLE  8'h77
`define EWSH_MASK_LENGTH 8'h9F

// style codes
`define EWSH_CODE_LIN1   4'h1
`define EWSH_CODE_LIN2   4'h2
`define EWSH_CODE_LIN3   4'h3
`define EWSH_CODE_LUT    4'h4
`define EWSH_CODE_LUTCOR 4'h5
`define EWSH_CODE_LUTADP 4'h6

// amplitude levels and supply reference
`define EWSH_AMP_FULL    8'hFF
`define EWSH_AMP_ZERO    8'h00
`define EWSH_SUPPLY_NOM  8'h80

`endif

// ==== hdl/ewsh_curve.v ====
// shape curve for one edge: linear segments or lookup tables, fraction 0..255
`timescale 1ns/1ps
`default_nettype none
`include "ewsh_consts.vh"

module ewsh_curve
(
  input  wire [3:0] code,
  input  wire [2:0] cfg,
  input  wire [7:0] prog,
  output reg  [7:0] shape
);

  // lookup tables sampled at eight progress points, each ends at full scale
  function [7:0] lut_pt;
    input [1:0] tbl;
    input [2:0] pt;
    begin
      case ({tbl, pt})
        5'd0: lut_pt = 8'h10;  5'd1: lut_pt = 8'h30;  5'd2: lut_pt = 8'h50;  5'd3: lut_pt = 8'h70;
        5'd4: lut_pt = 8'h90;  5'd5: lut_pt = 8'hB0;  5'd6: lut_pt = 8'hD0;  5'd7: lut_pt = 8'hFF;
        5'd8: lut_pt = 8'h04;  5'd9: lut_pt = 8'h10;  5'd10: lut_pt = 8'h24; 5'd11: lut_pt = 8'h40;
        5'd12: lut_pt = 8'h64; 5'd13: lut_pt = 8'h90; 5'd14: lut_pt = 8'hC4; 5'd15: lut_pt = 8'hFF;
        5'd16: lut_pt = 8'h3C; 5'd17: lut_pt = 8'h70; 5'd18: lut_pt = 8'h9C; 5'd19: lut_pt = 8'hC0;
        5'd20: lut_pt = 8'hDC; 5'd21: lut_pt = 8'hF0; 5'd22: lut_pt = 8'hFC; 5'd23: lut_pt = 8'hFF;
        5'd24: lut_pt = 8'h08; 5'd25: lut_pt = 8'h20; 5'd26: lut_pt = 8'h50; 5'd27: lut_pt = 8'h80;
        5'd28: lut_pt = 8'hB0; 5'd29: lut_pt = 8'hE0; 5'd30: lut_pt = 8'hF8; default: lut_pt = 8'hFF;
      endcase
    end
  endfunction

  // knee levels rise with the time constant: a larger constant front-loads the edge
  wire [8:0] knee2   = 9'd128 + {2'b00, cfg, 4'h0};
  wire [8:0] knee3a  = 9'd64 + {2'b00, cfg, 4'h0};
  wire [8:0] knee3b  = 9'd192 + {3'b000, cfg, 3'b000};
  wire [16:0] seg2lo = ({9'h000, prog} * {8'h00, knee2}) >> 7;
  // the last segment of each curve divides by its own span so full progress lands on full scale
  wire [16:0] seg2hi = ({9'h000, prog - 8'h80} * ({8'h00, 9'd255} - {8'h00, knee2})) / 17'h0007F;
  wire [16:0] seg3a  = ({9'h000, prog} * {8'h00, knee3a}) >> 6;
  wire [16:0] seg3b  = ({9'h000, prog - 8'h40} * ({8'h00, knee3b} - {8'h00, knee3a})) >> 7;
  wire [16:0] seg3c  = ({9'h000, prog - 8'hC0} * ({8'h00, 9'd255} - {8'h00, knee3b})) / 17'h0003F;

  // select the curve for the style code
  always @*
  begin
    case (code)
      `EWSH_CODE_LIN1: shape = prog;
      `EWSH_CODE_LIN2:
        shape = prog[7] ? (knee2[7:0] + seg2hi[7:0]) : seg2lo[7:0];
      `EWSH_CODE_LIN3:
        if (prog < 8'h40)
          shape = seg3a[7:0];
        else if (prog < 8'hC0)
          shape = knee3a[7:0] + seg3b[7:0];
        else
          shape = knee3b[7:0] + seg3c[7:0];
      `EWSH_CODE_LUT, `EWSH_CODE_LUTCOR, `EWSH_CODE_LUTADP:
        shape = lut_pt(cfg[1:0], prog[7:5]);
      default: shape = `EWSH_AMP_FULL; // reserved codes jump straight to the end level
    endcase
  end

endmodule // ewsh_curve
`default_nettype wire

// ==== hdl/ewsh_adapt.v ====
// supply adaptation of a table-shaped edge fraction
`timescale 1ns/1ps
`default_nettype none
`include "ewsh_consts.vh"

module ewsh_adapt
(
  input  wire [3:0] code,
  input  wire [7:0] shape,
  input  wire       last_state,
  input  wire [7:0] pa_supply_voltage,
  output reg  [7:0] adj
);

  // scale by supply over nominal; a higher supply drives the edge harder
  wire [15:0] scaled = ({8'h00, shape} * {8'h00, pa_supply_voltage}) >> 7;
  wire [7:0]  clip   = (scaled[15:8] != 8'h00) ? `EWSH_AMP_FULL : scaled[7:0];

  always @*
  begin
    case (code)
      `EWSH_CODE_LUTADP: adj = clip;
      // correction pins the last state to the exact end level despite scaling
      `EWSH_CODE_LUTCOR: adj = last_state ? `EWSH_AMP_FULL : clip;
      default:           adj = shape;
    endcase
  end

endmodule // ewsh_adapt
`default_nettype wire

// ==== hdl/ewsh_top.v ====
// transmit edge wave shaper with apb register file and pause edge sequencer
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "ewsh_consts.vh"

module ewsh_top
#(
  parameter AW = 12
)
(
  input  wire          pclk,
  input  wire          presetn,
  input  wire          psel,
  input  wire          penable,
  input  wire          pwrite,
  input  wire [AW-1:0] paddr,
  input  wire [31:0]   pwdata,
  output reg  [31:0]   prdata,
  output wire          pready,
  output wire          pslverr,
  input  wire          carrier_tick,
  input  wire          mod_pause,
  input  wire [7:0]    pa_supply_voltage,
  output reg  [7:0]    carrier_amplitude,
  output reg           edge_active
);

  // sequencer states, one-hot
  localparam [3:0] S_IDLE = 4'b0001;
  localparam [3:0] S_FALL = 4'b0010;
  localparam [3:0] S_HOLD = 4'b0100;
  localparam [3:0] S_RISE = 4'b1000;

  reg  [7:0] tx_edge_style_424_reg;
  reg  [7:0] tx_edge_length_424_reg;
  reg  [7:0] tx_residual_amplitude_848_reg;
  reg  [7:0] tx_edge_kind_848_reg;
  reg  [3:0] state_reg;
  reg  [3:0] state_next;
  reg  [4:0] idx_reg;
  reg  [4:0] idx_next;
  reg        sub_reg;
  reg        sub_next;
  reg  [7:0] amp_next;
  reg  [7:0] rdata_mux;
  reg        hit_mux;

  // byte addresses from register indices
  wire [AW-1:0] a_style  = {{(AW-10){1'b0}}, `EWSH_IDX_STYLE, 2'b00};
  wire [AW-1:0] a_length = {{(AW-10){1'b0}}, `EWSH_IDX_LENGTH, 2'b00};
  wire [AW-1:0] a_resid  = {{(AW-10){1'b0}}, `EWSH_IDX_RESID, 2'b00};
  wire [AW-1:0] a_kind   = {{(AW-10){1'b0}}, `EWSH_IDX_KIND, 2'b00};
  wire [AW-1:0] a_status = {{(AW-10){1'b0}}, `EWSH_IDX_STATUS, 2'b00};

  // apb slave
  // one wait-free access phase; read data is latched in the setup cycle
  // so prdata comes straight from a flip-flop
  assign pready  = psel & penable;
  assign pslverr = psel & penable & ~hit_mux;

  wire setup_rd = psel & ~penable & ~pwrite;
  wire wr_take  = psel & penable & pwrite;

  // address decode and read mux
  always @*
  begin
    hit_mux   = 1'b1;
    rdata_mux = 8'h00;
    if (paddr == a_style)
      rdata_mux = tx_edge_style_424_reg;
    else if (paddr == a_length)
      rdata_mux = tx_edge_length_424_reg;
    else if (paddr == a_resid)
      rdata_mux = tx_residual_amplitude_848_reg;
    else if (paddr == a_kind)
      rdata_mux = tx_edge_kind_848_reg;
    else if (paddr == a_status)
      rdata_mux = {carrier_amplitude[7:4], state_reg};
    else
      hit_mux = 1'b0;
  end

  // read data capture; unmapped reads give zero
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (setup_rd)
      prdata <= {24'h000000, rdata_mux};
  end

  // register writes take effect at the access edge; reserved bits stay zero
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_edge_style_424_reg         <= `EWSH_RST_STYLE;
      tx_edge_length_424_reg        <= `EWSH_RST_LENGTH;
      tx_residual_amplitude_848_reg <= `EWSH_RST_RESID;
      tx_edge_kind_848_reg          <= `EWSH_RST_KIND;
    end
    else if (wr_take)
    begin
      if (paddr == a_style)
        tx_edge_style_424_reg <= pwdata[7:0] & `EWSH_MASK_STYLE;
      if (paddr == a_length)
        tx_edge_length_424_reg <= pwdata[7:0] & `EWSH_MASK_LENGTH;
      if (paddr == a_resid)
        tx_residual_amplitude_848_reg <= pwdata[7:0];
      if (paddr == a_kind)
        tx_edge_kind_848_reg <= pwdata[7:0];
    end
  end

  // field extraction
  wire [3:0] fall_code = tx_edge_kind_848_reg[`EWSH_KIND_FALL];
  wire [3:0] rise_code = tx_edge_kind_848_reg[`EWSH_KIND_RISE];
  wire [2:0] fall_cfg  = tx_edge_style_424_reg[`EWSH_FALL_CFG];
  wire [2:0] rise_cfg  = tx_edge_style_424_reg[`EWSH_RISE_CFG];
  wire       scale2    = tx_edge_length_424_reg[`EWSH_SCALE_BIT];
  wire [4:0] nstates   = tx_edge_length_424_reg[`EWSH_NSTATE];
  wire [7:0] resid     = tx_residual_amplitude_848_reg;

  // a zero count or reserved code means the edge is a hard step
  wire fall_ok = (nstates != 5'd0) && (fall_code >= `EWSH_CODE_LIN1)
                 && (fall_code <= `EWSH_CODE_LUTADP);
  wire rise_ok = (nstates != 5'd0) && (rise_code >= `EWSH_CODE_LIN1)
                 && (rise_code <= `EWSH_CODE_LUTADP);

  // progress through the edge
  // progress of the current state as a fraction of 255; the divider is
  // combinational, which is cheap at these widths
  wire [4:0]  n_safe    = (nstates == 5'd0) ? 5'd1 : nstates;
  wire [13:0] num       = ({9'h000, idx_reg} + 14'h0001) * 14'h00FF;
  wire [13:0] prog_wide = num / {9'h000, n_safe};
  wire [7:0]  prog      = prog_wide[7:0];
  wire        last_st   = (idx_reg == n_safe - 5'd1);

  wire [7:0] fall_shape;
  wire [7:0] rise_shape;
  wire [7:0] adj;

  // falling edge curve
  ewsh_curve u_fall_curve
  (
    .code  (fall_code),
    .cfg   (fall_cfg),
    .prog  (prog),
    .shape (fall_shape)
  );

  // rising edge curve
  ewsh_curve u_rise_curve
  (
    .code  (rise_code),
    .cfg   (rise_cfg),
    .prog  (prog),
    .shape (rise_shape)
  );

  wire       in_rise  = (state_reg == S_RISE);
  wire [3:0] act_code = in_rise ? rise_code : fall_code;

  // supply adaptation of whichever edge is running
  ewsh_adapt u_adapt
  (
    .code              (act_code),
    .shape             (in_rise ? rise_shape : fall_shape),
    .last_state        (last_st),
    .pa_supply_voltage (pa_supply_voltage),
    .adj               (adj)
  );

  // blend between full carrier and the residual level
  wire [7:0]  delta   = `EWSH_AMP_FULL - resid;
  wire [15:0] part_w  = ({8'h00, delta} * {8'h00, adj}) / 16'h00FF;
  wire [7:0]  part    = part_w[7:0];
  wire [7:0]  fall_amp = `EWSH_AMP_FULL - part;
  wire [7:0]  rise_amp = resid + part;

  // a state ends on its last carrier cycle: one cycle, or the second of two
  wire state_done = carrier_tick & (~scale2 | sub_reg);

  // edge sequencer
  always @*
  begin
    state_next = state_reg;
    idx_next   = idx_reg;
    sub_next   = sub_reg;
    amp_next   = carrier_amplitude;
    case (state_reg)
      S_IDLE:
      begin
        amp_next = `EWSH_AMP_FULL;
        idx_next = 5'd0;
        sub_next = 1'b0;
        if (mod_pause)
        begin
          if (fall_ok)
            state_next = S_FALL;
          else
          begin
            state_next = S_HOLD;
            amp_next   = resid;
          end
        end
      end
      S_FALL, S_RISE:
      begin
        amp_next = in_rise ? rise_amp : fall_amp;
        if (carrier_tick)
          sub_next = scale2 & ~sub_reg;
        if (state_done)
        begin
          sub_next = 1'b0;
          if (last_st)
          begin
            idx_next   = 5'd0;
            state_next = in_rise ? S_IDLE : S_HOLD;
          end
          else
            idx_next = idx_reg + 5'd1;
        end
      end
      S_HOLD:
      begin
        amp_next = resid;
        idx_next = 5'd0;
        sub_next = 1'b0;
        if (!mod_pause)
        begin
          if (rise_ok)
            state_next = S_RISE;
          else
          begin
            state_next = S_IDLE;
            amp_next   = `EWSH_AMP_FULL;
          end
        end
      end
      default:
      begin
        state_next = S_IDLE;
        amp_next   = `EWSH_AMP_FULL;
        idx_next   = 5'd0;
        sub_next   = 1'b0;
      end
    endcase
  end

  // sequencer and output registers
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg         <= S_IDLE;
      idx_reg           <= 5'd0;
      sub_reg           <= 1'b0;
      carrier_amplitude <= `EWSH_AMP_FULL;
      edge_active       <= 1'b0;
    end
    else
    begin
      state_reg         <= state_next;
      idx_reg           <= idx_next;
      sub_reg           <= sub_next;
      carrier_amplitude <= amp_next;
      edge_active       <= (state_next == S_FALL) | (state_next == S_RISE);
    end
  end

endmodule // ewsh_top
`default_nettype wire

// ==== sim/ewsh_top_monitor.sv ====
// port assertions for the edge wave shaper
`timescale 1ns/1ps
`default_nettype none
module ewsh_top_monitor
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        carrier_tick,
  input wire logic        mod_pause,
  input wire logic [7:0]  carrier_amplitude,
  input wire logic        edge_active,
  input wire logic [7:0]  pa_supply_voltage
);
  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);
  // zero wait states: answer only inside the access phase
  property p_ready; pready == (psel && penable); endproperty
  a_ready: assert property (p_ready) else $error("pready outside access phase");
  property p_slverr; pslverr |-> psel && penable; endproperty
  a_slverr: assert property (p_slverr) else $error("pslverr outside access phase");
  property p_prhi; psel && penable |-> prdata[31:8] == 24'h0; endproperty
  a_prhi: assert property (p_prhi) else $error("upper read data not zero");
  // amplitude lags the state index by one clock, so only a tick one clock back may move it
  property p_hold; edge_active && $past(edge_active) && !$past(carrier_tick) && !psel
    |=> $stable(carrier_amplitude);
  endproperty
  a_hold: assert property (p_hold) else $error("amplitude moved without tick");
  property p_fell_tick; $fell(edge_active) |-> $past(carrier_tick); endproperty
  a_fell_tick: assert property (p_fell_tick) else $error("edge ended off tick");
  // without correction a low supply may leave the last rise state short of full
  property p_rise_end; $fell(edge_active) && !mod_pause && pa_supply_voltage[7]
    |-> carrier_amplitude == 8'hFF;
  endproperty
  a_rise_end: assert property (p_rise_end) else $error("rise not at full");
  // fall never climbs, rise never drops
  property p_fall_down; edge_active && mod_pause |=> carrier_amplitude <= $past(carrier_amplitude);
  endproperty
  a_fall_down: assert property (p_fall_down) else $error("falling edge rose");
  property p_rise_up; edge_active && !mod_pause |=> carrier_amplitude >= $past(carrier_amplitude);
  endproperty
  a_rise_up: assert property (p_rise_up) else $error("rising edge fell");
endmodule // ewsh_top_monitor

bind ewsh_top ewsh_top_monitor mon_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .carrier_tick(carrier_tick), .mod_pause(mod_pause),
  .carrier_amplitude(carrier_amplitude), .edge_active(edge_active),
  .pa_supply_voltage(pa_supply_voltage));
`default_nettype wire

// ==== sim/ewsh_top_tb.sv ====
// self-checking bench for the edge wave shaper
`timescale 1ns/1ps
`default_nettype none
`include "ewsh_consts.vh"
module ewsh_top_tb;
  logic        pclk, presetn, psel, penable, pwrite, pslverr, pready;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, lf;
  logic [7:0]  pa_supply_voltage, carrier_amplitude, r;
  logic        carrier_tick, mod_pause, edge_active, er;
  int          n_mismatch, n_checks, tc, i;
  logic [7:0]  ix [4] = '{`EWSH_IDX_STYLE, `EWSH_IDX_LENGTH, `EWSH_IDX_RESID, `EWSH_IDX_KIND};
  logic [7:0]  mk [4] = '{`EWSH_MASK_STYLE, `EWSH_MASK_LENGTH, 8'hFF, 8'hFF};
  int          cf [9] = '{1, 1, 2, 3, 4, 5, 6, 3, 1};
  int          cr [9] = '{1, 4, 3, 2, 6, 5, 1, 1, 6};
  int          nn [9] = '{1, 31, 5, 7, 4, 3, 6, 5, 0};
  int          sc [9] = '{0, 1, 0, 1, 0, 1, 0, 0, 1};

  ewsh_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .carrier_tick(carrier_tick), .mod_pause(mod_pause),
    .pa_supply_voltage(pa_supply_voltage), .carrier_amplitude(carrier_amplitude),
    .edge_active(edge_active));

  initial
  begin
    pclk = 0;
    forever #20 pclk = ~pclk;
  end

  // carrier tick every third clock, a slow carrier keeps states visible
  always @(posedge pclk)
  begin
    tc <= (tc == 2) ? 0 : tc + 1;
    carrier_tick <= (tc == 1);
  end

  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
  begin
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  end
  endtask

  task tally_and_finish;
  begin
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  end
  endtask

  function automatic logic [31:0] nxt(input logic [31:0] s);
    nxt = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // level of a state from its shape fraction a, integer maths
  function automatic logic [31:0] model(input bit f, input int rs, input int a);
  begin
    model = f ? 255 - (255 - rs) * a / 255 : rs + (255 - rs) * a / 255;
  end
  endfunction

  // one apb transfer, request held until pready
  task apb(input bit w, input logic [7:0] idx, input logic [7:0] d);
  begin
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1;
    // only the watchdog ends a wait for pready
    do
      @(posedge pclk);
    while (pready !== 1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  end
  endtask

  // one edge: count ticks; a state's level stands one clock after its tick
  task phase(input bit f, input int c, input int n, input int m, input int rs);
    int k, ne, pk, ea;
    bit pend;
  begin
    ne = (c >= 1 && c <= 6) ? n : 0;
    @(posedge pclk);
    mod_pause <= f;
    k = 0;
    pk = 0;
    pend = 0;
    @(posedge pclk);
    do
    begin
      @(posedge pclk);
      if (pend)
      begin
        ea = (c == 1) ? ((pk + 1) * 255) / ne : 255;
        if (c == 6)
          ea = (255 * pa_supply_voltage / 128 < 255) ? 255 * pa_supply_voltage / 128 : 255;
        chk(carrier_amplitude, model(f, rs, ea), "state");
      end
      pend = 0;
      if (edge_active === 1 && carrier_tick === 1)
      begin
        pk = k / m;
        pend = (c == 1) || (c >= 4 && c <= 6 && pk == ne - 1);
        k++;
      end
    end
    while (edge_active !== 0);
    // hold or idle settles one clock after the edge ends
    @(posedge pclk);
    chk(k, ne * m, "tick count");
    chk(carrier_amplitude, f ? rs : 255, "end level");
  end
  endtask

  initial
  begin
    presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    carrier_tick = 0; mod_pause = 0; pa_supply_voltage = 8'h80; lf = 32'h6619;
    n_mismatch = 0; n_checks = 0; tc = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1;
    // reset values, then reserved bits read back as zero
    for (i = 0; i < 4; i++)
    begin
      apb(0, ix[i], 8'h0);
      chk(rd, 32'h0, "reset value");
      apb(1, ix[i], 8'hFF);
      apb(0, ix[i], 8'h0);
      chk(rd, {24'h0, mk[i]}, "write mask");
    end
    apb(1, `EWSH_IDX_STATUS, 8'h00);
    apb(0, `EWSH_IDX_STATUS, 8'h00);
    chk(rd, 32'hF1, "status idle");
    apb(0, 8'h10, 8'h00);
    chk({rd[30:0], er}, 32'h1, "unmapped read");
    $display("test registers done");
    for (i = 0; i < 9; i++)
    begin
      lf = nxt(lf);
      r = lf[7:0];
      apb(1, `EWSH_IDX_RESID, r);
      apb(1, `EWSH_IDX_STYLE, lf[15:8] & 8'h77);
      apb(1, `EWSH_IDX_LENGTH, {sc[i][0], 2'b00, nn[i][4:0]});
      apb(1, `EWSH_IDX_KIND, {cf[i][3:0], cr[i][3:0]});
      pa_supply_voltage <= lf[23:16];
      phase(1, cf[i], nn[i], sc[i] + 1, r);
      repeat (4) @(posedge pclk);
      phase(0, cr[i], nn[i], sc[i] + 1, r);
      $display("test edge %0d done", i);
    end
    tally_and_finish;
  end

  // watchdog well beyond the expected thousand or so cycles
  initial
  begin
    repeat (40000) @(posedge pclk);
    n_mismatch++;
    tally_and_finish;
  end
endmodule // ewsh_top_tb
`default_nettype wire
